// ---- rtl/lemu_pkg.sv ----
// package: register map, field layout and timing constants of the link error monitor and user io
package lemu_pkg;
   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] LEMU_OFS_THRESHOLD = 8'h15;
   localparam logic [7:0] LEMU_OFS_COUNT = 8'h16;
   localparam logic [7:0] LEMU_OFS_USER = 8'h17;
   // ***************************************************************
   // user register fields
   // ***************************************************************
   localparam int LEMU_BIT_SENSE0 = 0;
   localparam int LEMU_BIT_SENSE1 = 1;
   localparam int LEMU_BIT_ENABLE0 = 2;
   localparam int LEMU_BIT_ENABLE1 = 3;
   localparam int LEMU_BIT_SENSE2 = 4;
   localparam int LEMU_BIT_ENABLE2 = 6;
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] LEMU_RST_COUNT = 8'h00;
   localparam logic [7:0] LEMU_RST_THRESHOLD = 8'h00;
   localparam logic [7:0] LEMU_RST_USER = 8'h00;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int LEMU_CLK_PERIOD_PS = 5000;
   localparam int LEMU_SENSE_MIN_PS = 20000;
   localparam int LEMU_SENSE_MIN_CYC =
      (LEMU_SENSE_MIN_PS + LEMU_CLK_PERIOD_PS - 1) / LEMU_CLK_PERIOD_PS;
endpackage : lemu_pkg

// ---- rtl/lemu_sense_if.sv ----
// interface: one sense pin filter and its latch control
`timescale 1ns/1ps
interface lemu_sense_if;
   logic pin;
   logic clear;
   logic active;
   logic flag;
   modport filt (input pin, input clear, input active, output flag);
   modport user (output pin, output clear, output active, input flag);
endinterface : lemu_sense_if

// ---- rtl/lemu_sense_latch.sv ----
// sense pin synchroniser, minimum-high filter and sticky flag
`timescale 1ns/1ps
module lemu_sense_latch
   import lemu_pkg::*;
#(
   parameter int MIN_CYC = LEMU_SENSE_MIN_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   lemu_sense_if.filt sif
);
   logic sync1_q;
   logic sync2_q;
   logic [7:0] run_q;
   logic flag_q;
   logic held;

   // first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= sif.pin;
         sync2_q <= sync1_q;
      end
   end

   assign held = sync2_q && (run_q >= 8'(MIN_CYC - 1));

   // ***************************************************************
   // high-time counter
   // ***************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 8'h00;
      end else if (!sync2_q) begin
         run_q <= 8'h00;
      end else if (!held) begin
         run_q <= run_q + 8'h01;
      end
   end

   // set beats clear in the same cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (sif.active && held) begin
         flag_q <= 1'b1;
      end else if (sif.clear || !sif.active) begin
         flag_q <= 1'b0;
      end
   end

   assign sif.flag = flag_q;
endmodule : lemu_sense_latch

// ---- rtl/lemu_regs.sv ----
// link error monitor counter, threshold, count snapshot and user sense/enable register
`timescale 1ns/1ps
module lemu_regs
   import lemu_pkg::*;
#(
   parameter bit DUAL_PATH = 1'b1,
   parameter int SENSE_MIN_CYC = LEMU_SENSE_MIN_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] cbus_addr,
   input wire logic cbus_wr,
   input wire logic cbus_rd,
   input wire logic [7:0] cbus_wdata,
   output logic [7:0] cbus_rdata,
   input wire logic link_error,
   input wire logic sense_input_zero,
   input wire logic sense_input_one,
   input wire logic sense_input_two,
   output logic enable_output_zero,
   output logic enable_output_one,
   output logic enable_output_two,
   output logic link_error_threshold_flag,
   output logic write_reject_flag
);
   // ***************************************************************
   // storage
   // ***************************************************************
   // bit two of each 3-bit vector belongs to the dual-path channel
   logic [7:0] threshold_q;
   logic [7:0] count_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_mux;
   logic [7:0] user_rd;
   logic [2:0] enable_q;
   logic [2:0] sense_flag;
   logic [2:0] sense_pin;
   logic [2:0] sense_clr;
   logic [2:0] sense_act;
   logic sel_thr;
   logic sel_cnt;
   logic sel_usr;
   logic wr_thr;
   logic wr_cnt;
   logic wr_usr;
   logic at_reload;
   logic err_taken;
   logic reload_hit;

   // ***************************************************************
   // address decode
   // ***************************************************************
   // unmapped addresses select nothing: reads give zero, writes vanish
   // a read and a write in one cycle both act
   assign sel_thr = (cbus_addr == LEMU_OFS_THRESHOLD);
   assign sel_cnt = (cbus_addr == LEMU_OFS_COUNT);
   assign sel_usr = (cbus_addr == LEMU_OFS_USER);
   assign wr_thr = cbus_wr && sel_thr;
   assign wr_cnt = cbus_wr && sel_cnt;
   assign wr_usr = cbus_wr && sel_usr;

   // ***************************************************************
   // threshold register
   // ***************************************************************
   // a write mid-count restarts the count as well
   // a value of 0 makes every error a threshold event
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         threshold_q <= LEMU_RST_THRESHOLD;
      end else if (wr_thr) begin
         threshold_q <= cbus_wdata;
      end
   end

   // ***************************************************************
   // link error down-counter
   // ***************************************************************
   // reload at 1 as well as at 0: the step to zero and the reload share one
   // edge, and a counter left at 0 by reset or a zero threshold still reloads
   assign at_reload = (count_q == 8'h01) || (count_q == 8'h00);
   // a threshold write outranks an error in the same cycle; the error is dropped
   assign err_taken = link_error && !wr_thr;
   assign reload_hit = err_taken && at_reload;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= LEMU_RST_COUNT;
      end else if (wr_thr) begin
         count_q <= cbus_wdata;
      end else if (reload_hit) begin
         count_q <= threshold_q;
      end else if (err_taken) begin
         count_q <= count_q - 8'h01;
      end
   end

   // ***************************************************************
   // interrupt condition pulses
   // ***************************************************************
   // one cycle each; the condition register outside holds the sticky bits
   // and owns their clearing, so nothing here needs a clear input
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         link_error_threshold_flag <= 1'b0;
      end else begin
         link_error_threshold_flag <= reload_hit;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         write_reject_flag <= 1'b0;
      end else begin
         write_reject_flag <= wr_cnt;
      end
   end

   // ***************************************************************
   // enable bits and pins
   // ***************************************************************
   // written as a whole byte; the sense positions of that byte act as clears
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         enable_q <= {LEMU_RST_USER[LEMU_BIT_ENABLE2], LEMU_RST_USER[LEMU_BIT_ENABLE1],
                      LEMU_RST_USER[LEMU_BIT_ENABLE0]};
      end else if (wr_usr) begin
         enable_q[0] <= cbus_wdata[LEMU_BIT_ENABLE0];
         enable_q[1] <= cbus_wdata[LEMU_BIT_ENABLE1];
         // single-path variant keeps the third enable at zero
         enable_q[2] <= DUAL_PATH & cbus_wdata[LEMU_BIT_ENABLE2];
      end
   end

   // pins follow the bits directly, high for 1 and low for 0
   assign enable_output_zero = enable_q[0];
   assign enable_output_one = enable_q[1];
   assign enable_output_two = enable_q[2];

   // ***************************************************************
   // sense channels
   // ***************************************************************
   // pins are asynchronous; each latch synchronises its own
   assign sense_pin[0] = sense_input_zero;
   assign sense_pin[1] = sense_input_one;
   assign sense_pin[2] = sense_input_two;
   // writing 0 clears a sense bit, writing 1 leaves it alone
   assign sense_clr[0] = wr_usr && !cbus_wdata[LEMU_BIT_SENSE0];
   assign sense_clr[1] = wr_usr && !cbus_wdata[LEMU_BIT_SENSE1];
   assign sense_clr[2] = wr_usr && !cbus_wdata[LEMU_BIT_SENSE2];
   // third channel idles in the single-path variant
   assign sense_act[0] = 1'b1;
   assign sense_act[1] = 1'b1;
   assign sense_act[2] = DUAL_PATH;

   // filter length is a parameter so a bench can shorten it
   for (genvar i = 0; i < 3; i++) begin : g_sense
      lemu_sense_if sif ();
      assign sif.pin = sense_pin[i];
      assign sif.clear = sense_clr[i];
      assign sif.active = sense_act[i];
      assign sense_flag[i] = sif.flag;
      lemu_sense_latch #(.MIN_CYC(SENSE_MIN_CYC)) u_latch (
         .mclk(mclk),
         .rst_b(rst_b),
         .sif(sif)
      );
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // sense flags and enable bits share one byte; gaps read as zero
   always_comb begin
      user_rd = 8'h00;
      user_rd[LEMU_BIT_SENSE0] = sense_flag[0];
      user_rd[LEMU_BIT_SENSE1] = sense_flag[1];
      user_rd[LEMU_BIT_ENABLE0] = enable_q[0];
      user_rd[LEMU_BIT_ENABLE1] = enable_q[1];
      user_rd[LEMU_BIT_SENSE2] = sense_flag[2];
      user_rd[LEMU_BIT_ENABLE2] = enable_q[2];
   end

   // unmapped addresses read zero
   always_comb begin
      unique case (cbus_addr)
         LEMU_OFS_THRESHOLD: rd_mux = threshold_q;
         LEMU_OFS_COUNT: rd_mux = count_q;
         LEMU_OFS_USER: rd_mux = user_rd;
         default: rd_mux = 8'h00;
      endcase
   end

   // registered on the read strobe so the snapshot is frozen at that cycle;
   // between reads the last byte stands, so a slow host may sample late
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else if (cbus_rd) begin
         rdata_q <= rd_mux;
      end
   end

   assign cbus_rdata = rdata_q;
endmodule : lemu_regs

// ---- verif/lemu_checker.sv ----
// checker: bus, counter flag and enable pin relations of the register block
`timescale 1ns/1ps
module lemu_checker (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] cbus_addr,
   input wire logic cbus_wr,
   input wire logic cbus_rd,
   input wire logic [7:0] cbus_wdata,
   input wire logic [7:0] cbus_rdata,
   input wire logic link_error,
   input wire logic enable_output_zero,
   input wire logic enable_output_one,
   input wire logic enable_output_two,
   input wire logic link_error_threshold_flag,
   input wire logic write_reject_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_wr(a); cbus_wr && cbus_addr == a; endsequence
   sequence s_wr_rd(a, b); s_wr(a) ##1 (cbus_rd && cbus_addr == b); endsequence
   a_reject_on_write: assert property (
      s_wr(8'h16) |=> write_reject_flag) else $error("reject pulse missing");
   a_reject_no_cause: assert property (
      !(cbus_wr && cbus_addr == 8'h16) |=> !write_reject_flag) else $error("stray reject");
   a_thr_read_back: assert property (
      s_wr_rd(8'h15, 8'h15) |=> cbus_rdata == $past(cbus_wdata, 2)) else $error("thr readback");
   a_count_loads_thr: assert property (
      s_wr_rd(8'h15, 8'h16) |=> cbus_rdata == $past(cbus_wdata, 2)) else $error("count load");
   a_enable_zero_pin: assert property (
      s_wr(8'h17) |=> enable_output_zero == $past(cbus_wdata[2])) else $error("pin zero");
   a_enable_one_pin: assert property (
      s_wr(8'h17) |=> enable_output_one == $past(cbus_wdata[3])) else $error("pin one");
   a_enable_two_pin: assert property (
      s_wr(8'h17) |=> enable_output_two == $past(cbus_wdata[6])) else $error("pin two");
   a_enable_pins_hold: assert property (
      !(cbus_wr && cbus_addr == 8'h17) |=> $stable({enable_output_zero, enable_output_one,
      enable_output_two})) else $error("pins moved");
   a_flag_has_error: assert property (
      link_error_threshold_flag |-> $past(link_error)) else $error("flag without error");
   a_rdata_holds: assert property (
      !cbus_rd |=> $stable(cbus_rdata)) else $error("read data moved");
endmodule : lemu_checker
bind lemu_regs lemu_checker chk_u (.mclk(mclk), .rst_b(rst_b), .cbus_addr(cbus_addr),
   .cbus_wr(cbus_wr), .cbus_rd(cbus_rd), .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata),
   .link_error(link_error), .enable_output_zero(enable_output_zero),
   .enable_output_one(enable_output_one), .enable_output_two(enable_output_two),
   .link_error_threshold_flag(link_error_threshold_flag),
   .write_reject_flag(write_reject_flag));

// ---- verif/lemu_host_model.sv ----
// host model: control bus master, one strobe cycle per call
`timescale 1ns/1ps
module lemu_host_model (
   input wire logic mclk,
   input wire logic [7:0] cbus_rdata,
   output logic [7:0] cbus_addr = 8'h00,
   output logic cbus_wr = 1'b0,
   output logic cbus_rd = 1'b0,
   output logic [7:0] cbus_wdata = 8'h00
);
   // idle data line gets junk so a stale byte is never trusted
   task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      cbus_wr = w;
      cbus_rd = r;
      cbus_addr = a;
      cbus_wdata = w ? d : ~cbus_wdata;
   endtask : cyc
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1'b0, 1'b1, a, 8'h00);
      cyc(1'b0, 1'b0, a, 8'h00);
      d = cbus_rdata;
   endtask : rd
endmodule : lemu_host_model

// ---- verif/test_link_error_monitor_user_io.sv ----
// testbench: counter, snapshot, reject, user register and sense latch
`timescale 1ns/1ps
module test_link_error_monitor_user_io;
   import lemu_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, link_error = 1'b0, wr, rd, e0, e1, e2, lf, rf;
   logic [2:0] sp = 3'b000;
   logic [7:0] addr, wdata, rdata, cnt, thr, d;
   int fails = 0, num_checks = 0, flags = 0, ef = 0;
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   // sampled mid-cycle, where the one-cycle pulse has settled
   always @(negedge mclk) flags += (lf === 1'b1);
   lemu_host_model host_u (.mclk(mclk), .cbus_rdata(rdata), .cbus_addr(addr), .cbus_wr(wr),
      .cbus_rd(rd), .cbus_wdata(wdata));
   lemu_regs dut_u (.mclk(mclk), .rst_b(rst_b), .cbus_addr(addr), .cbus_wr(wr),
      .cbus_rd(rd), .cbus_wdata(wdata), .cbus_rdata(rdata), .link_error(link_error),
      .sense_input_zero(sp[0]), .sense_input_one(sp[1]), .sense_input_two(sp[2]),
      .enable_output_zero(e0), .enable_output_one(e1), .enable_output_two(e2),
      .link_error_threshold_flag(lf), .write_reject_flag(rf));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host_u.rd(a, v);
      chk(v, exp);
   endtask : rchk
   // counter at one or zero reloads instead of wrapping
   task automatic errs(input int n);
      repeat (n) begin
         @(negedge mclk);
         link_error = 1'b1;
         ef += (cnt <= 8'h01);
         cnt = (cnt <= 8'h01) ? thr : cnt - 8'h01;
      end
      @(negedge mclk);
      link_error = 1'b0;
   endtask : errs
   function automatic logic [7:0] sb(input int s);
      return (s == 2) ? 8'h10 : 8'h01 << s;
   endfunction : sb
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      report_and_stop();
   end
   initial begin
      d = 8'($urandom(32'h73d79c30));
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      rchk(LEMU_OFS_COUNT, 8'h00);
      rchk(8'h20, 8'h00);
      {cnt, thr} = 16'h0000;
      errs(1);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         thr = (i == 0) ? 8'hff : 8'($urandom_range(2, 12));
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_THRESHOLD, thr);
         rchk(LEMU_OFS_THRESHOLD, thr);
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_THRESHOLD, thr);
         rchk(LEMU_OFS_COUNT, thr);
         cnt = thr;
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_COUNT, ~thr);
         rchk(LEMU_OFS_COUNT, cnt);
         errs((i == 0) ? 256 : $urandom_range(1, 30));
         rchk(LEMU_OFS_COUNT, cnt);
         chk(8'(flags), 8'(ef));
      end
      $display("test counter done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_USER, d);
         rchk(LEMU_OFS_USER, d & 8'h4c);
         chk({5'h00, e2, e1, e0}, {5'h00, d[6], d[3], d[2]});
      end
      host_u.cyc(1'b1, 1'b0, LEMU_OFS_USER, 8'h00);
      host_u.cyc(1'b0, 1'b0, LEMU_OFS_USER, 8'h00);
      $display("test user done");
      for (int s = 0; s < 3; s++) begin
         sp[s] = 1'b1;
         repeat (2) @(negedge mclk);
         sp[s] = 1'b0;
         rchk(LEMU_OFS_USER, 8'h00);
         sp[s] = 1'b1;
         repeat (10) @(negedge mclk);
         sp[s] = 1'b0;
         rchk(LEMU_OFS_USER, sb(s));
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_USER, sb(s));
         rchk(LEMU_OFS_USER, sb(s));
         host_u.cyc(1'b1, 1'b0, LEMU_OFS_USER, 8'h00);
         rchk(LEMU_OFS_USER, 8'h00);
      end
      $display("test sense done");
      report_and_stop();
   end
endmodule : test_link_error_monitor_user_io
